// [common/bsd_pkg.sv]
/*
 * constants for the boot section address decoder: pointer field layout,
 * boot section start table, region split, command codes and fsm states.
 * assumes nothing of its surroundings; shared by all design files.
 */
`default_nettype none

package bsd_pkg;

  // ==========================================================
  // variants and pointer layout
  localparam int PC_W_SMALL   = 13;  // 13-bit program counter
  localparam int PC_W_LARGE   = 14;  // 14-bit program counter
  localparam int WORD_W       = 6;   // 64 words in a page
  localparam int PTR_W        = 16;  // pointer register width
  localparam int PTR_WORD_LSB = 1;   // bit 0 is the byte select
  localparam int PTR_WORD_MSB = 6;   // in-page word top bit
  localparam int PTR_PAGE_LSB = 7;   // page field lowest bit

  // ==========================================================
  // boot section start per size field, 13-bit variant
  localparam logic [13:0] BOOT_SMALL_11 = 14'h1F80;  // 128 words
  localparam logic [13:0] BOOT_SMALL_10 = 14'h1F00;  // 256 words
  localparam logic [13:0] BOOT_SMALL_01 = 14'h1E00;  // 512 words
  localparam logic [13:0] BOOT_SMALL_00 = 14'h1C00;  // 1024 words
  // boot section start per size field, 14-bit variant
  localparam logic [13:0] BOOT_LARGE_11 = 14'h3F00;  // 256 words
  localparam logic [13:0] BOOT_LARGE_10 = 14'h3E00;  // 512 words
  localparam logic [13:0] BOOT_LARGE_01 = 14'h3C00;  // 1024 words
  localparam logic [13:0] BOOT_LARGE_00 = 14'h3800;  // 2048 words

  // ==========================================================
  // first word of the no-read-while-write region
  localparam logic [13:0] NO_READ_WHILE_WRITE_REGION_SMALL = 14'h1C00;  // 112 pages below
  localparam logic [13:0] NO_READ_WHILE_WRITE_REGION_LARGE = 14'h3800;  // 224 pages below
  localparam logic [13:0] APP_BASE   = 14'h0000;  // application start

  // ==========================================================
  // command codes from the core
  localparam logic [1:0] CMD_FILL  = 2'h0;  // temporary buffer fill
  localparam logic [1:0] CMD_ERASE = 2'h1;  // page erase
  localparam logic [1:0] CMD_WRITE = 2'h2;  // page write
  localparam logic [1:0] CMD_REEN  = 2'h3;  // re-enable region reads

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } bsd_state_t;

endpackage

`default_nettype wire

// [rtl/bsd_region_map.sv]
/*
 * boot size decode and region classification of one page number.
 * assumes the page field is already cut from the pointer; purely
 * combinational, the caller registers what it needs.
 */
`default_nettype none

module bsd_region_map
  import bsd_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b0,
  parameter int PC_W        = 13,
  parameter int PG_W        = 7
) (
  input  wire logic [1:0]      bootSize,   // {hi, lo} boot size fuse
  input  wire logic [PG_W-1:0] pageIn,     // page to classify
  output logic      [PC_W-1:0] bootStart,  // boot reset address
  output logic      [PC_W-1:0] appEnd,     // last application word
  output logic                 inBoot,     // page inside boot section
  output logic                 inNrww      // page inside no_read_while_write_region region
);

  // ==========================================================
  // size table lookup
  function automatic logic [13:0] bootStartOf(input logic big,
                                              input logic [1:0] sz);
    logic [13:0] r;
    r = big ? BOOT_LARGE_00 : BOOT_SMALL_00;
    case (sz)
      2'b11: r = big ? BOOT_LARGE_11 : BOOT_SMALL_11;
      2'b10: r = big ? BOOT_LARGE_10 : BOOT_SMALL_10;
      2'b01: r = big ? BOOT_LARGE_01 : BOOT_SMALL_01;
      default: r = big ? BOOT_LARGE_00 : BOOT_SMALL_00;
    endcase
    return r;
  endfunction

  logic [13:0] fullStart;
  logic [13:0] fullNrww;
  logic [PC_W-1:0] nrwwStart;

  // boot start and application end from the fuse field
  assign fullStart = bootStartOf(BIG_VARIANT, bootSize);
  assign bootStart = fullStart[PC_W-1:0];
  assign appEnd    = fullStart[PC_W-1:0] - PC_W'(1);
  assign fullNrww  = BIG_VARIANT ? NO_READ_WHILE_WRITE_REGION_LARGE : NO_READ_WHILE_WRITE_REGION_SMALL;
  assign nrwwStart = fullNrww[PC_W-1:0];

  // page compare against section starts; page granularity suffices
  // since every boundary is page aligned
  assign inBoot = pageIn >= bootStart[PC_W-1:WORD_W];
  assign inNrww = pageIn >= nrwwStart[PC_W-1:WORD_W];

endmodule

`default_nettype wire

// [rtl/bsd_boot_decode.sv]
/*
 * boot section address decoder and page operation sequencer of the
 * flash self-programming unit. splits the core's pointer into page
 * and word fields, decodes the boot section and region split, and
 * tracks the region busy flag and core stall for erase and write.
 * assumes the core holds cmdValid until cmdReady, and the flash array
 * pulses opDone once per started erase or write.
 */
// Operation
// - 13-bit variant: size 11/10/01/00 start at 1F80/1F00/1E00/1C00
// - boot reset is boot start; application ends one word below it
// - 14-bit variant: size 11/10/01/00 start at 3F00/3E00/3C00/3800
// - 13-bit variant: 0000-1BFF read-while-write, 1C00-1FFF not
// - 14-bit variant: 0000-37FF read-while-write, 3800-3FFF not
// - 13-bit counter: bits 5..0 word, bits 12..6 page
// - 14-bit counter: bits 5..0 word, bits 13..6 page
// - word from pointer 6..1, page from pointer 13/14..7
// - pointer bits above the page field are ignored
// - pointer bit 0 selects the byte for loads; stores keep it zero
// - page field only for erase/write, word field only for fill
// - erase/write in read-while-write region sets busy, blocks reads
// - core stalls for the whole operation on no-read-while-write page
// - erase/write page comes from the pointer's upper part only
`default_nettype none

module bsd_boot_decode
  import bsd_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b0,
  localparam int PC_W = BIG_VARIANT ? PC_W_LARGE : PC_W_SMALL,
  localparam int PG_W = PC_W - WORD_W
) (
  input  wire logic             clock,            // 100 MHz core clock
  input  wire logic             rst,              // async reset, high
  input  wire logic             clockEn,          // freezes state when low
  input  wire logic             bootSizeSelHi,    // boot size fuse bit 1
  input  wire logic             bootSizeSelLo,    // boot size fuse bit 0
  input  wire logic [PTR_W-1:0] pointer,          // core pointer register
  input  wire logic             cmdValid,         // store command request
  input  wire logic [1:0]       cmdKind,          // fill/erase/write/reen
  output logic                  cmdReady,         // command accepted
  input  wire logic             loadReq,          // program memory load
  input  wire logic             opDone,           // flash op finished
  output logic                  opStart,          // erase/write start pulse
  output logic                  opIsWrite,        // started op is a write
  output logic                  fillStrobe,       // buffer fill pulse
  output logic      [PG_W-1:0]  pageSelectField,  // target page
  output logic      [WORD_W-1:0] wordSelectField, // buffer word
  output logic                  byteSelect,       // load byte select
  output logic      [PC_W-1:0]  bootResetAddr,    // boot start word
  output logic      [PC_W-1:0]  appEndAddr,       // last app word
  output logic                  inBootSection,    // pointer in boot
  output logic                  inNrwwRegion,     // pointer in no_read_while_write_region
  output logic                  regionBusyFlag,   // rww region busy
  output logic                  rwwReadBlock,     // rww reads refused
  output logic                  coreStall,        // halt the core
  output logic                  flashBusy         // op in progress
);

  // ==========================================================
  // pointer fields
  logic [PG_W-1:0]   ptrPage;
  logic [WORD_W-1:0] ptrWord;
  logic [PC_W-1:0]   mapStart;
  logic [PC_W-1:0]   mapEnd;
  logic              mapBoot;
  logic              mapNrww;

  // upper pointer bits never reach the field, so they are ignored
  assign ptrPage = pointer[PC_W:PTR_PAGE_LSB];
  assign ptrWord = pointer[PTR_WORD_MSB:PTR_WORD_LSB];

  bsd_region_map #(
    .BIG_VARIANT (BIG_VARIANT),
    .PC_W        (PC_W),
    .PG_W        (PG_W)
  ) uMap (
    .bootSize  ({bootSizeSelHi, bootSizeSelLo}),
    .pageIn    (ptrPage),
    .bootStart (mapStart),
    .appEnd    (mapEnd),
    .inBoot    (mapBoot),
    .inNrww    (mapNrww)
  );

  // ==========================================================
  // command decode
  bsd_state_t state;
  bsd_state_t next_state;
  logic       take;
  logic       isProg;
  logic       isFill;
  logic       isReen;
  logic       setBusy;
  logic       clrBusy;
  logic       next_regionBusy;
  logic       targetNrww;

  // one command at a time; the core waits out a running op
  assign cmdReady = (state == ST_IDLE);
  assign take     = cmdValid && cmdReady;
  assign isProg   = (cmdKind == CMD_ERASE) || (cmdKind == CMD_WRITE);
  assign isFill   = (cmdKind == CMD_FILL);
  assign isReen   = (cmdKind == CMD_REEN);

  // busy flag: set by a rww erase/write, cleared by re-enable or fill;
  // set wins so a start is never lost under a same-cycle clear
  assign setBusy = take && isProg && !mapNrww;
  assign clrBusy = take && (isReen || isFill);
  assign next_regionBusy = setBusy || (regionBusyFlag && !clrBusy);

  // status outputs seen by the core
  assign flashBusy    = (state == ST_BUSY);
  assign coreStall    = flashBusy && targetNrww;
  assign rwwReadBlock = regionBusyFlag;

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && isProg) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (opDone) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state and busy flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ST_IDLE;
      regionBusyFlag <= 1'b0;
    end else if (clockEn) begin
      state          <= next_state;
      regionBusyFlag <= next_regionBusy;
    end
  end

  // start and fill pulses, one enabled cycle each
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opStart    <= 1'b0;
      fillStrobe <= 1'b0;
    end else if (clockEn) begin
      opStart    <= take && isProg;
      fillStrobe <= take && isFill;
    end
  end

  // page latched only for erase/write; data registers play no part
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pageSelectField <= '0;
      opIsWrite       <= 1'b0;
      targetNrww      <= 1'b0;
    end else if (clockEn && take && isProg) begin
      pageSelectField <= ptrPage;
      opIsWrite       <= (cmdKind == CMD_WRITE);
      targetNrww      <= mapNrww;
    end
  end

  // word latched only for fills; a write's word field is unused,
  // so a nonzero one from software does no harm here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wordSelectField <= '0;
    end else if (clockEn && take && isFill) begin
      wordSelectField <= ptrWord;
    end
  end

  // byte select only for loads; stores never look at bit 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byteSelect <= 1'b0;
    end else if (clockEn && loadReq) begin
      byteSelect <= pointer[0];
    end
  end

  // decoded section info, refreshed every enabled cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bootResetAddr <= '0;
      appEndAddr    <= '0;
      inBootSection <= 1'b0;
      inNrwwRegion  <= 1'b0;
    end else if (clockEn) begin
      bootResetAddr <= mapStart;
      appEndAddr    <= mapEnd;
      inBootSection <= mapBoot;
      inNrwwRegion  <= mapNrww;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [PC_W-1:0] nrwwBase;
  logic [PC_W-1:0] ptrAddr;
  assign nrwwBase = PC_W'(BIG_VARIANT ? NO_READ_WHILE_WRITE_REGION_LARGE : NO_READ_WHILE_WRITE_REGION_SMALL);
  assign ptrAddr  = {ptrPage, ptrWord};

  a_busy_set: assert property (
    clockEn && take && isProg && !mapNrww |=> regionBusyFlag && flashBusy
  ) else $error("region busy not set on rww erase/write");

  a_busy_hold: assert property (
    regionBusyFlag && !(clockEn && take && (isFill || isReen))
      |=> regionBusyFlag
  ) else $error("region busy dropped without re-enable or fill");

  a_stall_no_read_while_write_region: assert property (
    clockEn && take && isProg && mapNrww |=> coreStall
  ) else $error("core not stalled during no_read_while_write_region operation");

  // the stall may only end on an accepted done pulse
  a_stall_hold: assert property (
    coreStall && !(clockEn && opDone) |=> coreStall
  ) else $error("core stall dropped before the operation ended");

  a_stall_rww: assert property (
    clockEn && take && isProg && !mapNrww |=> !coreStall && opStart
  ) else $error("core stalled during rww operation");

  a_page_latch: assert property (
    clockEn && take && isProg |=> pageSelectField == $past(ptrPage)
  ) else $error("page field not taken from pointer");

  a_fill_word: assert property (
    clockEn && take && isFill
      |=> fillStrobe && wordSelectField == $past(ptrWord)
          && $stable(pageSelectField)
  ) else $error("fill word wrong or page disturbed");

  a_byte_pick: assert property (
    clockEn && loadReq |=> byteSelect == $past(pointer[0])
  ) else $error("load byte select not from pointer bit 0");

  a_no_read_while_write_region_split: assert property (
    clockEn |=> inNrwwRegion == ($past(ptrAddr) >= nrwwBase)
  ) else $error("region split wrong");

  // registers still hold reset zeros at the first edge after release
  a_boot_span: assert property (
    !$past(rst) |-> appEndAddr + PC_W'(1) == bootResetAddr
      && bootResetAddr >= nrwwBase && bootResetAddr[WORD_W-1:0] == '0
  ) else $error("boot start or application end wrong");

  c_rww_write: cover property (
    clockEn && take && cmdKind == CMD_WRITE && !mapNrww
  );
  c_no_read_while_write_region_erase: cover property (
    clockEn && take && cmdKind == CMD_ERASE && mapNrww
  );
  c_reenable: cover property (
    regionBusyFlag && clockEn && take && isReen ##1 !regionBusyFlag
  );

endmodule

`default_nettype wire

// [verif/bsd_flash_model.sv]
/*
 * flash array stand-in for the boot decoder: answers each started
 * erase or write with a one-cycle done pulse after a set delay.
 * assumes opStart is a one-cycle pulse and opDelay is at least 1.
 */
`default_nettype none

module bsd_flash_model (
  input  wire logic       clock,    // core clock
  input  wire logic       rst,      // async reset, high
  input  wire logic       opStart,  // erase/write start pulse
  input  wire logic [7:0] opDelay,  // cycles until done
  output logic            opDone    // done pulse to the decoder
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] remain;

  // ==========================================================
  // countdown; the bench varies the delay so fast and slow arrays are both seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain <= 8'h00;
      opDone <= 1'b0;
    end else begin
      opDone <= 1'b0;
      if (opStart) begin
        remain <= opDelay;
      end else if (remain != 8'h00) begin
        remain <= remain - 8'h01;
        opDone <= (remain == 8'h01);  // never early, never twice
      end
    end
  end
endmodule

`default_nettype wire

// [verif/tb_boot_section_address_decode.sv]
/*
 * self-checking bench for the boot section decoder: size table, region
 * split, pointer fields, erase/write/fill/re-enable and loads.
 * assumes the flash model answers every started operation.
 */
`default_nettype none

module tb_boot_section_address_decode;
  import bsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam bit BIG  = 1'b0;
  localparam int PC_W = BIG ? 14 : 13;
  localparam int PG_W = PC_W - 6;
  localparam logic [15:0] JUNK = BIG ? 16'h8000 : 16'hC000;  // above the page field
  localparam logic [13:0] NO_READ_WHILE_WRITE_REGION = BIG ? 14'h3800 : 14'h1C00;

  logic              clock, rst, clockEn, bootSizeSelHi, bootSizeSelLo, cmdValid;
  logic              loadReq, opDone, cmdReady, opStart, opIsWrite, fillStrobe;
  logic              byteSelect, inBootSection, inNrwwRegion, regionBusyFlag;
  logic              rwwReadBlock, coreStall, flashBusy;
  logic [PTR_W-1:0]  pointer;
  logic [1:0]        cmdKind;
  logic [7:0]        opDelay;
  logic [PG_W-1:0]   pageSelectField;
  logic [WORD_W-1:0] wordSelectField;
  logic [PC_W-1:0]   bootResetAddr, appEndAddr;
  int                mismatches, checked;

  bsd_boot_decode #(.BIG_VARIANT(BIG)) DUT (
    .clock           (clock),
    .rst             (rst),
    .clockEn         (clockEn),
    .bootSizeSelHi   (bootSizeSelHi),
    .bootSizeSelLo   (bootSizeSelLo),
    .pointer         (pointer),
    .cmdValid        (cmdValid),
    .cmdKind         (cmdKind),
    .cmdReady        (cmdReady),
    .loadReq         (loadReq),
    .opDone          (opDone),
    .opStart         (opStart),
    .opIsWrite       (opIsWrite),
    .fillStrobe      (fillStrobe),
    .pageSelectField (pageSelectField),
    .wordSelectField (wordSelectField),
    .byteSelect      (byteSelect),
    .bootResetAddr   (bootResetAddr),
    .appEndAddr      (appEndAddr),
    .inBootSection   (inBootSection),
    .inNrwwRegion    (inNrwwRegion),
    .regionBusyFlag  (regionBusyFlag),
    .rwwReadBlock    (rwwReadBlock),
    .coreStall       (coreStall),
    .flashBusy       (flashBusy)
  );
  bsd_flash_model partner (
    .clock   (clock),
    .rst     (rst),
    .opStart (opStart),
    .opDelay (opDelay),
    .opDone  (opDone)
  );

  // ==========================================================
  // clock, watchdog and shared helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run needs well under 2000 cycles
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [13:0] bootStartOf(input logic [1:0] sz);
    logic [13:0] t [4];
    if (BIG) begin
      t = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    end else begin
      t = '{14'h1C00, 14'h1E00, 14'h1F00, 14'h1F80};
    end
    return t[sz];
  endfunction

  // word address to pointer: bit 0 is the byte select, so shift up one
  function automatic logic [15:0] ptrOf(input logic [13:0] a);
    return {1'b0, a, 1'b0} | JUNK;
  endfunction

  task automatic issue(input logic [1:0] k, input logic [15:0] p);
    @(negedge clock);
    chk("cmdReady", cmdReady, 1);
    cmdValid = 1'b1;
    cmdKind  = k;
    pointer  = p;
    @(negedge clock);
    cmdValid = 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_boot();
    for (int s = 0; s < 4; s++) begin
      @(negedge clock);
      {bootSizeSelHi, bootSizeSelLo} = s[1:0];
      repeat (2) @(negedge clock);
      chk("bootResetAddr", bootResetAddr, bootStartOf(s[1:0]));
      chk("appEndAddr", appEndAddr, bootStartOf(s[1:0]) - 14'h0001);
    end
    $display("test boot_size done");
  endtask

  task automatic t_region();
    logic [13:0] a [4];
    a = '{NO_READ_WHILE_WRITE_REGION - 14'h0040, NO_READ_WHILE_WRITE_REGION, bootStartOf(2'b11) - 14'h0040, bootStartOf(2'b11)};
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      pointer = ptrOf(a[i]) | 16'h007F;
      repeat (2) @(negedge clock);
      chk("inNrwwRegion", inNrwwRegion, i != 0);
      chk("inBootSection", inBootSection, i == 3);
    end
    $display("test region_split done");
  endtask

  task automatic t_op(input logic [1:0] k, input logic [13:0] a, input logic [7:0] d,
                      input bit reen);
    int n;
    bit no_read_while_write_region;
    no_read_while_write_region = a >= NO_READ_WHILE_WRITE_REGION;
    opDelay = d;
    issue(k, ptrOf(a));  // word field zero for writes
    chk("opStart", opStart, 1);
    chk("opIsWrite", opIsWrite, k == CMD_WRITE);
    chk("pageSelectField", pageSelectField, a[PC_W-1:6]);
    chk("cmdReady", cmdReady, 0);
    chk("regionBusyFlag", regionBusyFlag, !no_read_while_write_region);
    chk("rwwReadBlock", rwwReadBlock, !no_read_while_write_region);
    n = 0;
    while (flashBusy === 1'b1 && n < 100) begin
      chk("coreStall", coreStall, no_read_while_write_region);
      @(negedge clock);
      n++;
    end
    chk("flashBusy", flashBusy, 0);
    chk("coreStall", coreStall, 0);
    chk("regionBusyFlag", regionBusyFlag, !no_read_while_write_region);
    if (reen) begin
      issue(CMD_REEN, 16'h0000);
      chk("regionBusyFlag", regionBusyFlag, 0);
    end
    $display("test page_op done");
  endtask

  // fill clears a busy region and touches only the word field
  task automatic t_fill();
    issue(CMD_FILL, JUNK | 16'h0280 | {9'h000, 6'h2A, 1'b0});  // stores keep bit 0 low
    chk("fillStrobe", fillStrobe, 1);
    chk("wordSelectField", wordSelectField, 6'h2A);
    chk("pageSelectField", pageSelectField, 1);
    chk("opStart", opStart, 0);
    chk("regionBusyFlag", regionBusyFlag, 0);
    @(negedge clock);
    chk("fillStrobe", fillStrobe, 0);
    $display("test fill done");
  endtask

  task automatic t_load();
    for (int b = 1; b >= 0; b--) begin
      @(negedge clock);
      pointer = 16'h1234 | b[0];
      loadReq = 1'b1;
      @(negedge clock);
      loadReq = 1'b0;
      chk("byteSelect", byteSelect, b[0]);
    end
    // frozen clock enable must keep the last byte select
    @(negedge clock);
    clockEn = 1'b0;
    pointer = 16'h0001;
    loadReq = 1'b1;
    @(negedge clock);
    loadReq = 1'b0;
    clockEn = 1'b1;
    chk("byteSelect", byteSelect, 0);
    $display("test load done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    clockEn = 1'b1;
    {bootSizeSelHi, bootSizeSelLo} = 2'b11;
    pointer = 16'h0000;
    cmdValid = 1'b0;
    cmdKind = CMD_FILL;
    loadReq = 1'b0;
    opDelay = 8'h02;
    mismatches = 0;
    checked = 0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_boot();
    @(negedge clock);
    {bootSizeSelHi, bootSizeSelLo} = 2'b11;
    t_region();
    t_op(CMD_ERASE, 14'h0040, 8'h01, 1'b0);
    t_fill();
    t_op(CMD_WRITE, NO_READ_WHILE_WRITE_REGION + 14'h0040, 8'h14, 1'b0);
    t_op(CMD_ERASE, NO_READ_WHILE_WRITE_REGION, 8'h03, 1'b0);
    t_op(CMD_WRITE, NO_READ_WHILE_WRITE_REGION - 14'h0040, 8'h05, 1'b1);
    t_load();
    stop_test();
  end
endmodule

`default_nettype wire
